//--- core/alias_match.v
// one alias comparator with address remap
`timescale 1ns/100ps
module alias_match #(
  parameter AW = 7
) (
  input  wire [AW-1:0] alias_i,
  input  wire [AW-1:0] phys_i,
  input  wire [AW-1:0] addr_i,
  output wire          hit_o,
  output wire [AW-1:0] phys_o
);
  // zero alias disables the decoder entry
  assign hit_o  = (alias_i != {AW{1'b0}}) && (alias_i == addr_i);
  assign phys_o = phys_i;
endmodule // alias_match

//--- core/ccr_top.v
// control channel config: rate select, remote id, alias decode and target remap
//
// What this block does
// - the two-bit return link rate code resets to 00 (2.5 Mbps), 01 selects 1.5625 Mbps, 10 and 11 are reserved.
// - after any change of the rate code the return link may show errors for a short settling window.
// - the remote bridge id sits in bits 7:1, resets to zero and normally loads from the forward link.
// - with the hold bit 0 set the id stops auto-loading and keeps the software-written value.
// - a local address equal to the remote bridge alias in bits 7:1 goes to the remote side.
// - a zero alias disables matching through that alias.
// - with alias bit 0 set, every local write to the remote bridge is acknowledged regardless of link state.
// - a local address matching target alias n, and neither the bridge alias nor a lower target alias, is replaced by physical address n before forwarding.
// - each target alias register holds in bits 7:1 the local address the decoder matches.
// - a transaction is forwarded only when pass-through on match (bit 6) is on and an alias matches.
`timescale 1ns/100ps
`include "ccr_defs.vh"
module ccr_top (
  input  wire        CLK_I,
  input  wire        RST_N_I,
  // apb slave
  input  wire        PSEL_I,
  input  wire        PENABLE_I,
  input  wire        PWRITE_I,
  input  wire [11:0] PADDR_I,
  input  wire [31:0] PWDATA_I,
  output reg  [31:0] PRDATA_O,
  output reg         PREADY_O,
  output reg         PSLVERR_O,
  // forward link id report (from pins)
  input  wire        FWD_ID_VALID_I,
  input  wire [6:0]  FWD_ID_I,
  input  wire        FWD_LOCK_I,
  // local transaction address request (same clock)
  input  wire        REQ_VALID_I,
  input  wire [6:0]  REQ_ADDR_I,
  input  wire        REQ_WRITE_I,
  input  wire        REMOTE_ACK_I,
  // decision
  output reg         FWD_VALID_O,
  output reg  [6:0]  FWD_ADDR_O,
  output reg         LOCAL_ACK_O,
  output reg  [1:0]  RATE_CODE_O,
  output reg         BC_ENABLE_O,
  output reg         BC_CRC_EN_O,
  output reg         RATE_SETTLING_O
);

  // ====================================================
  // pin synchronisers
  // id bits and their valid cross separately; the id is only taken once
  // the synchronised valid has stood for two edges, so every id bit has settled
  reg       idv1_q;
  reg       idv2_q;
  reg       idv3_q;
  reg [6:0] id1_q;
  reg [6:0] id2_q;
  reg       lock1_q;
  reg       lock2_q;
  always @(posedge CLK_I) begin
    if (!RST_N_I) begin
      idv1_q  <= 1'b0;
      idv2_q  <= 1'b0;
      idv3_q  <= 1'b0;
      id1_q   <= 7'h00;
      id2_q   <= 7'h00;
      lock1_q <= 1'b0;
      lock2_q <= 1'b0;
    end else begin
      idv1_q  <= FWD_ID_VALID_I;
      idv2_q  <= idv1_q;
      idv3_q  <= idv2_q;
      id1_q   <= FWD_ID_I;
      id2_q   <= id1_q;
      lock1_q <= FWD_LOCK_I;
      lock2_q <= lock1_q;
    end
  end

  // limitation: the far side must hold the id steady while its valid is high
  wire id_load = idv2_q && idv3_q;

  // ====================================================
  // registers
  reg [7:0] cfg_q;
  reg [1:0] rate_q;
  reg [7:0] rsvd59_q;
  reg [7:0] rsvd5a_q;
  reg [7:0] rid_q;
  reg [7:0] ralias_q;
  reg [6:0] tphys_q  [0:2];
  reg [7:0] talias_q [0:2];

  wire       acc      = PSEL_I && PENABLE_I && PREADY_O;
  wire       wr       = acc && PWRITE_I;
  wire       aligned  = (PADDR_I[1:0] == 2'h0);
  wire [7:0] idx      = PADDR_I[9:2];
  wire       hi_zero  = (PADDR_I[11:10] == 2'h0);
  wire       wr_ok    = wr && aligned && hi_zero;
  wire       we_cfg   = wr_ok && (idx == `IDX_RETURN_LINK_CFG);
  wire       we_rid   = wr_ok && (idx == `IDX_REMOTE_ID);
  // rate field sits in bits 1:0 of the config word; only a real change restarts the window
  wire       rate_wr  = we_cfg && (PWDATA_I[1:0] != rate_q);

  integer i;
  always @(posedge CLK_I) begin
    if (!RST_N_I) begin
      cfg_q    <= `RST_RETURN_LINK_CFG;
      rate_q   <= `RATE_2P5;
      rsvd59_q <= `RST_REG8;
      rsvd5a_q <= `RST_REG8;
      ralias_q <= `RST_REG8;
      for (i = 0; i < 3; i = i + 1) begin
        tphys_q[i]  <= 7'h00;
        talias_q[i] <= `RST_REG8;
      end
    end else begin
      if (wr_ok) begin
        case (idx)
          `IDX_RETURN_LINK_CFG: begin
            cfg_q  <= {PWDATA_I[7:2], 2'h0};
            rate_q <= PWDATA_I[1:0];
          end
          `IDX_RSVD_59:       rsvd59_q    <= PWDATA_I[7:0];
          `IDX_RSVD_5A:       rsvd5a_q    <= PWDATA_I[7:0];
          `IDX_REMOTE_ID:     ; // id register has its own process below
          `IDX_REMOTE_ALIAS:  ralias_q    <= PWDATA_I[7:0];
          `IDX_TARGET_ADDR_0: tphys_q[0]  <= PWDATA_I[7:1];
          `IDX_TARGET_ADDR_1: tphys_q[1]  <= PWDATA_I[7:1];
          `IDX_TARGET_ADDR_2: tphys_q[2]  <= PWDATA_I[7:1];
          `IDX_TARGET_ALIAS_0: talias_q[0] <= PWDATA_I[7:0];
          `IDX_TARGET_ALIAS_1: talias_q[1] <= PWDATA_I[7:0];
          `IDX_TARGET_ALIAS_2: talias_q[2] <= PWDATA_I[7:0];
          default: ;
        endcase
      end
    end
  end

  // ====================================================
  // remote bridge id: a software write beats a same-cycle auto-load
  reg [7:0] rid_d;
  always @* begin
    rid_d = rid_q;
    if (we_rid) begin
      rid_d = PWDATA_I[7:0];
    end else if (!rid_q[0] && id_load) begin
      rid_d = {id2_q, 1'b0};
    end
  end

  always @(posedge CLK_I) begin
    if (!RST_N_I) begin
      rid_q <= `RST_REG8;
    end else begin
      rid_q <= rid_d;
    end
  end

  // ====================================================
  // apb read path: one wait state, answer in second access cycle
  reg [7:0] rd_byte;
  reg       mapped;
  always @* begin
    mapped  = 1'b1;
    rd_byte = 8'h00;
    case (idx)
      `IDX_RETURN_LINK_CFG: rd_byte = {cfg_q[7:2], rate_q};
      `IDX_RSVD_59:         rd_byte = rsvd59_q;
      `IDX_RSVD_5A:         rd_byte = rsvd5a_q;
      `IDX_REMOTE_ID:       rd_byte = rid_q;
      `IDX_REMOTE_ALIAS:    rd_byte = ralias_q;
      `IDX_TARGET_ADDR_0:   rd_byte = {tphys_q[0], 1'b0};
      `IDX_TARGET_ADDR_1:   rd_byte = {tphys_q[1], 1'b0};
      `IDX_TARGET_ADDR_2:   rd_byte = {tphys_q[2], 1'b0};
      `IDX_TARGET_ALIAS_0:  rd_byte = talias_q[0];
      `IDX_TARGET_ALIAS_1:  rd_byte = talias_q[1];
      `IDX_TARGET_ALIAS_2:  rd_byte = talias_q[2];
      default:              mapped  = 1'b0;
    endcase
    if (!aligned || !hi_zero) begin
      mapped = 1'b0;
    end
  end

  // ready low in the first access cycle is the single wait state
  reg        pready_d;
  reg        pslverr_d;
  reg [31:0] prdata_d;
  always @* begin
    pready_d  = 1'b0;
    pslverr_d = 1'b0;
    prdata_d  = 32'h00000000;
    if (PSEL_I && PENABLE_I && !PREADY_O) begin
      pready_d  = 1'b1;
      pslverr_d = !mapped;
      if (mapped && !PWRITE_I) begin
        prdata_d = {24'h000000, rd_byte};
      end
    end
  end

  always @(posedge CLK_I) begin
    if (!RST_N_I) begin
      PREADY_O  <= 1'b0;
      PRDATA_O  <= 32'h00000000;
      PSLVERR_O <= 1'b0;
    end else begin
      PREADY_O  <= pready_d;
      PRDATA_O  <= prdata_d;
      PSLVERR_O <= pslverr_d;
    end
  end

  // ====================================================
  // rate change settling
  wire settling;
  settle_timer u_settle (
    .CLK_I   (CLK_I),
    .RST_N_I (RST_N_I),
    .start_i (rate_wr),
    .busy_o  (settling)
  );

  // ====================================================
  // alias decode
  wire [2:0] thit;
  wire [6:0] tphys_w [0:2];
  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : g_tgt
      alias_match u_match (
        .alias_i (talias_q[g][7:1]),
        .phys_i  (tphys_q[g]),
        .addr_i  (REQ_ADDR_I),
        .hit_o   (thit[g]),
        .phys_o  (tphys_w[g])
      );
    end
  endgenerate

  wire       bhit;
  wire [6:0] bphys;
  alias_match u_bridge (
    .alias_i (ralias_q[7:1]),
    .phys_i  (rid_q[7:1]),
    .addr_i  (REQ_ADDR_I),
    .hit_o   (bhit),
    .phys_o  (bphys)
  );

  // bridge alias first, then lowest target index
  reg [6:0] sel_addr;
  always @* begin
    if (bhit) begin
      sel_addr = bphys;
    end else if (thit[0]) begin
      sel_addr = tphys_w[0];
    end else if (thit[1]) begin
      sel_addr = tphys_w[1];
    end else begin
      sel_addr = tphys_w[2];
    end
  end

  wire any_hit = bhit || (|thit);
  wire fwd_ok  = REQ_VALID_I && cfg_q[`BIT_PASS_MATCH] && any_hit;
  // auto-ack ignores lock and remote answer; host relies on it during rate change
  wire auto    = REQ_WRITE_I && ((bhit && ralias_q[0]) || cfg_q[`BIT_AUTOACK_ALL]);

  // ====================================================
  // decision: forward, remapped address and local acknowledge
  reg       fwd_valid_d;
  reg [6:0] fwd_addr_d;
  reg       local_ack_d;
  always @* begin
    fwd_valid_d = 1'b0;
    fwd_addr_d  = 7'h00;
    local_ack_d = 1'b0;
    if (fwd_ok) begin
      fwd_valid_d = 1'b1;
      fwd_addr_d  = sel_addr;
    end
    if (REQ_VALID_I && (auto || (fwd_ok && lock2_q && REMOTE_ACK_I))) begin
      local_ack_d = 1'b1;
    end
  end

  always @(posedge CLK_I) begin
    if (!RST_N_I) begin
      FWD_VALID_O     <= 1'b0;
      FWD_ADDR_O      <= 7'h00;
      LOCAL_ACK_O     <= 1'b0;
      RATE_CODE_O     <= `RATE_2P5;
      BC_ENABLE_O     <= 1'b1;
      BC_CRC_EN_O     <= 1'b1;
      RATE_SETTLING_O <= 1'b0;
    end else begin
      FWD_VALID_O     <= fwd_valid_d;
      FWD_ADDR_O      <= fwd_addr_d;
      LOCAL_ACK_O     <= local_ack_d;
      RATE_CODE_O     <= rate_q;
      BC_ENABLE_O     <= cfg_q[`BIT_BC_ENABLE];
      BC_CRC_EN_O     <= cfg_q[`BIT_BC_CRC];
      RATE_SETTLING_O <= settling;
    end
  end
endmodule // ccr_top

//--- core/settle_timer.v
// counts a fixed settling window after a trigger pulse
`timescale 1ns/100ps
`include "ccr_defs.vh"
module settle_timer (
  input  wire CLK_I,
  input  wire RST_N_I,
  input  wire start_i,
  output reg  busy_o
);
  reg [9:0] cnt_q;
  always @(posedge CLK_I) begin
    if (!RST_N_I) begin
      cnt_q  <= 10'h000;
      busy_o <= 1'b0;
    end else if (start_i) begin
      cnt_q  <= `SETTLE_LOAD;
      busy_o <= 1'b1;
    end else if (cnt_q != 10'h000) begin
      cnt_q  <= cnt_q - 10'h001;
    end else begin
      busy_o <= 1'b0;
    end
  end
endmodule // settle_timer

//--- inc/ccr_defs.vh
// register offsets, field positions, reset values and timing for the control channel remap block
`ifndef CCR_DEFS_VH
`define CCR_DEFS_VH
// ====================================================
// register indices (byte address is four times the index)
`define IDX_RETURN_LINK_CFG  8'h58
`define IDX_RSVD_59          8'h59
`define IDX_RSVD_5A          8'h5a
`define IDX_REMOTE_ID        8'h5b
`define IDX_REMOTE_ALIAS     8'h5c
`define IDX_TARGET_ADDR_0    8'h5d
`define IDX_TARGET_ADDR_1    8'h5e
`define IDX_TARGET_ADDR_2    8'h5f
`define IDX_TARGET_ALIAS_0   8'h65
`define IDX_TARGET_ALIAS_1   8'h66
`define IDX_TARGET_ALIAS_2   8'h67
// ====================================================
// field positions in return_link_config
`define BIT_PASS_ALL         7
`define BIT_PASS_MATCH       6
`define BIT_AUTOACK_ALL      5
`define BIT_BC_ENABLE        4
`define BIT_BC_CRC           3
// ====================================================
// reset values
`define RST_RETURN_LINK_CFG  8'h18
`define RST_REG8             8'h00
`define RATE_2P5             2'h0
`define RATE_1P5625          2'h1
// ====================================================
// timing: settling window after a rate change
`define SETTLE_TIME_NS       2000
`define CLK_PERIOD_NS        5
`define SETTLE_CYCLES        (`SETTLE_TIME_NS / `CLK_PERIOD_NS)
// counter load, one less than the window length
`define SETTLE_LOAD          10'h18f
`endif

//--- sim/ccr_link_model.sv
// far-side model: remote bridge id report, lock and remote ack
`timescale 1ns/100ps
module ccr_link_model #(
  parameter [6:0] ID = 7'h2a
) (
  input  wire       clk_i,
  input  wire       go_i,
  output reg        id_valid_o = 1'b0,
  output reg  [6:0] id_o       = 7'h00,
  output reg        lock_o     = 1'b0,
  output reg        ack_o      = 1'b0
);
  // idle id lines toggle so a stale value is never mistaken for a report
  always @(posedge clk_i) begin
    id_valid_o <= go_i;
    id_o       <= go_i ? ID : ~id_o;
    lock_o     <= go_i;
    ack_o      <= go_i;
  end
endmodule // ccr_link_model

//--- sim/ccr_top_chk.sv
// concurrent checks on the control channel remap ports
`timescale 1ns/100ps
module ccr_top_chk (
  input wire       CLK_I,
  input wire       RST_N_I,
  input wire       PSEL_I,
  input wire       PENABLE_I,
  input wire       PREADY_O,
  input wire       PSLVERR_O,
  input wire       REQ_VALID_I,
  input wire       REQ_WRITE_I,
  input wire       FWD_VALID_O,
  input wire [6:0] FWD_ADDR_O,
  input wire       LOCAL_ACK_O,
  input wire [1:0] RATE_CODE_O,
  input wire       RATE_SETTLING_O
);
  // ====================================================
  // checks
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RST_N_I);
  sequence s_access;
    PSEL_I && !PENABLE_I ##1 PSEL_I && PENABLE_I;
  endsequence
  a_ready_wait: assert property (s_access |=> PREADY_O) else $error("ready late");
  a_err_ready: assert property (PSLVERR_O |-> PREADY_O) else $error("error without ready");
  a_rate_reset: assert property ($rose(RST_N_I) |-> RATE_CODE_O == 2'h0) else $error("rate reset");
  a_settle_start: assert property ($changed(RATE_CODE_O) |-> ##[0:2] RATE_SETTLING_O)
    else $error("no settle window");
  a_settle_hold: assert property ($rose(RATE_SETTLING_O) |=> RATE_SETTLING_O [*8])
    else $error("settle too short");
  a_fwd_cause: assert property (FWD_VALID_O || LOCAL_ACK_O |-> $past(REQ_VALID_I))
    else $error("output without request");
  a_fwd_addr: assert property (!FWD_VALID_O |-> FWD_ADDR_O == 7'h00) else $error("stray addr");
  a_ack_nofwd: assert property (LOCAL_ACK_O && !FWD_VALID_O |-> $past(REQ_WRITE_I))
    else $error("ack on read miss");
endmodule // ccr_top_chk
bind ccr_top ccr_top_chk i_chk (.CLK_I(CLK_I), .RST_N_I(RST_N_I), .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I),
  .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O), .REQ_VALID_I(REQ_VALID_I), .REQ_WRITE_I(REQ_WRITE_I),
  .FWD_VALID_O(FWD_VALID_O), .FWD_ADDR_O(FWD_ADDR_O), .LOCAL_ACK_O(LOCAL_ACK_O), .RATE_CODE_O(RATE_CODE_O),
  .RATE_SETTLING_O(RATE_SETTLING_O));

//--- sim/control_channel_addr_remap_bench.sv
// self-checking bench for the control channel remap block
`timescale 1ns/100ps
`include "ccr_defs.vh"
module control_channel_addr_remap_bench;
  logic        clk = 1'b0, rst_n = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0, go = 1'b0;
  logic        req_v = 1'b0, req_w = 1'b0, pready, pslverr, fid_v, lock, rack, fwd_v, lack, e;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwd = 32'h0, prdata, r;
  logic [6:0]  req_a = 7'h00, fid, fwd_a;
  logic [1:0]  rate;
  logic        bce, bcc, settle;
  int          fails = 0, checks_done = 0;
  // index, write byte, read-back byte
  logic [23:0] rows [9] = '{24'h586060, 24'h5b3535, 24'h5c4141, 24'h5d2322, 24'h5e4544, 24'h5f6766,
                            24'h656060, 24'h666262, 24'h670000};
  ccr_link_model i_link (.clk_i(clk), .go_i(go), .id_valid_o(fid_v), .id_o(fid), .lock_o(lock), .ack_o(rack));
  ccr_top i_dut (.CLK_I(clk), .RST_N_I(rst_n), .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(paddr),
    .PWDATA_I(pwd), .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr), .FWD_ID_VALID_I(fid_v),
    .FWD_ID_I(fid), .FWD_LOCK_I(lock), .REQ_VALID_I(req_v), .REQ_ADDR_I(req_a), .REQ_WRITE_I(req_w),
    .REMOTE_ACK_I(rack), .FWD_VALID_O(fwd_v), .FWD_ADDR_O(fwd_a), .LOCAL_ACK_O(lack), .RATE_CODE_O(rate),
    .BC_ENABLE_O(bce), .BC_CRC_EN_O(bcc), .RATE_SETTLING_O(settle));
  // ====================================================
  // tasks
  task check(input [31:0] s, input [31:0] x);
    checks_done++;
    if (s !== x) begin
      fails++;
      $display("mismatch at %0t: seen %h expected %h", $time, s, x);
    end
  endtask
  task results;
    if (fails == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // byte address is four times the index; waits on pready, never a fixed count
  task apb(input [7:0] i, input w, input [7:0] d);
    psel <= 1'b1; pwr <= w; paddr <= {2'b00, i, 2'b00}; pwd <= {24'h0, d};
    @(posedge clk) pen <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    r = prdata; e = pslverr;
    psel <= 1'b0; pen <= 1'b0;
    @(posedge clk);
  endtask
  task creq(input [6:0] a, input w, input [8:0] x);
    req_v <= 1'b1; req_a <= a; req_w <= w;
    @(posedge clk) req_v <= 1'b0;
    #1 check({23'h0, fwd_v, fwd_a, lack}, {23'h0, x});
    @(posedge clk);
  endtask
  // ====================================================
  // sequence
  initial forever #2.5 clk = ~clk;
  initial begin
    #20000 fails++;
    results;
  end
  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    check({18'h0, fwd_v, fwd_a, lack, rate, bce, bcc, settle}, 32'h6);
    foreach (rows[k]) begin
      apb(rows[k][23:16], 1'b0, 8'h00);
      check(r, rows[k][23:16] == 8'h58 ? 32'h18 : 32'h0);
    end
    go <= 1'b1;
    foreach (rows[k]) begin
      apb(rows[k][23:16], 1'b1, rows[k][15:8]);
      apb(rows[k][23:16], 1'b0, 8'h00);
      check(r, {24'h0, rows[k][7:0]});
    end
    check({30'h0, bce, bcc}, 32'h0);
    creq(7'h20, 1'b1, {1'b1, 7'h1a, 1'b1});
    creq(7'h30, 1'b0, {1'b1, 7'h11, 1'b1});
    creq(7'h31, 1'b1, {1'b1, 7'h22, 1'b1});
    creq(7'h00, 1'b0, 9'h000);
    creq(7'h55, 1'b1, 9'h001);
    apb(8'h58, 1'b1, 8'h20);
    creq(7'h30, 1'b0, 9'h000);
    for (int c = 0; c < 4; c++) begin
      apb(8'h58, 1'b1, 8'h60 | c[7:0]);
      @(posedge clk);
      check({30'h0, rate}, c);
    end
    check({31'h0, settle}, 32'h1);
    repeat (`SETTLE_CYCLES - 8) @(posedge clk);
    check({31'h0, settle}, 32'h1);
    repeat (8) @(posedge clk);
    check({31'h0, settle}, 32'h0);
    apb(8'h5b, 1'b1, 8'h00);
    repeat (8) @(posedge clk);
    apb(8'h5b, 1'b0, 8'h00);
    check(r, 32'h54);
    apb(8'h60, 1'b0, 8'h00);
    check({31'h0, e}, 32'h1);
    check(r, 32'h0);
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    check({18'h0, fwd_v, fwd_a, lack, rate, bce, bcc, settle}, 32'h6);
    apb(8'h58, 1'b0, 8'h00);
    check(r, 32'h18);
    results;
  end
endmodule // control_channel_addr_remap_bench
